//--- hdl/cscr_device.sv
// configuration register bank with output dividers, sync and lock detect
`timescale 1ns/100ps
`include "cscr_params.svh"
module cscr_device (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  cscr_link_if.dev          link,
  input  wire logic         phase_in_window,
  output logic [11:0]       clock_output_n,
  output logic [5:0]        pair_path_off,
  output logic [5:0][10:0]  pair_divide_value,
  output logic [5:0]        pair_extended,
  output logic [5:0]        pair_sync_exclude,
  output logic              device_powerdown,
  output logic              soft_reset_bit,
  output logic              crystal_osc_on,
  output logic              reference_doubler_on,
  output logic [4:0]        lock_pin_select,
  output logic [2:0]        lock_pin_driver,
  output logic [1:0]        charge_pump_gain,
  output logic [13:0]       lock_detect_count,
  output logic [11:0]       ref_div,
  output logic [17:0]       fb_div,
  output logic [17:0]       fb_cal_div,
  output logic [2:0]        fb_prescale,
  output logic              register_write_lock,
  output logic              digital_lock_detect,
  output logic              sync_active
);

  cscr_pkg::cscr_dev_s st_reg;
  cscr_pkg::cscr_dev_s st_next;

  // ---------------------------------------------
  // power-on contents of the bank
  // ---------------------------------------------
  // also the soft reset image, so both paths load the same values except register 0 bit 17, which soft reset sets
  function automatic cscr_pkg::cscr_bank_t dev_defaults();
    cscr_pkg::cscr_bank_t b;
    b = '0;
    for (int p = 0; p < `CSCR_NPAIR; p++) begin
      b[p] = `CSCR_D_PAIR;
    end
    b[3]                = `CSCR_D_PAIR3;
    b[`CSCR_A_SYNC]     = `CSCR_D_SYNC;
    b[`CSCR_A_LDPIN]    = `CSCR_D_LDPIN;
    b[`CSCR_A_GPO0]     = `CSCR_D_GPO0;
    b[`CSCR_A_GPO1]     = `CSCR_D_GPO1;
    b[`CSCR_A_PLLGAIN]  = `CSCR_D_PLLGAIN;
    b[`CSCR_A_REFDIV]   = `CSCR_D_REFDIV;
    b[`CSCR_A_CALDIV]   = `CSCR_D_CALDIV;
    b[`CSCR_A_FBDIV]    = `CSCR_D_FBDIV;
    return b;
  endfunction

  function automatic logic [10:0] div_of(input logic [31:0] w);
    return w[`CSCR_B_DIV_HI:`CSCR_B_DIV_LO];
  endfunction

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    logic        rise;
    logic        fall;
    logic [4:0]  addr;
    logic [31:0] data;
    logic        taken;
    logic        hold;
    logic [10:0] dv;
    logic        stop;
    logic [11:0] per;
    rise  = 1'b0;
    fall  = 1'b0;
    addr  = '0;
    data  = '0;
    taken = 1'b0;
    hold  = 1'b0;
    dv    = '0;
    stop  = 1'b0;
    per   = '0;
    st_next = st_reg;

    // second stage only feeds logic; the first is a pure synchroniser
    st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
    st_next.sdat_s = {st_reg.sdat_s[0], link.sdata};
    st_next.le_s   = {st_reg.le_s[0], link.latch_en};
    st_next.ok_s   = {st_reg.ok_s[0], phase_in_window};
    st_next.sclk_d = st_reg.sclk_s[1];
    st_next.le_d   = st_reg.le_s[1];
    rise = st_reg.sclk_s[1] & ~st_reg.sclk_d;
    fall = st_reg.le_d & ~st_reg.le_s[1];

    if (rise) begin
      st_next.shift = {st_reg.shift[30:0], st_reg.sdat_s[1]};
    end

    // ---------------------------------------------
    // commit of a serial frame
    // ---------------------------------------------
    if (st_reg.sync_cnt != 4'h0) begin
      st_next.sync_cnt = st_reg.sync_cnt - 4'h1;
    end
    addr  = st_reg.shift[4:0];
    data  = {st_reg.shift[31:5], 5'h00};
    taken = (addr == `CSCR_A_WLOCK) |
            ~st_reg.regs[`CSCR_A_WLOCK][`CSCR_B_WLOCK];
    if (fall && taken) begin
      if (addr == `CSCR_A_R0 && data[`CSCR_B_SOFT_RST]) begin
        st_next.regs = dev_defaults();
        // the rest of this frame is dropped on purpose
        st_next.regs[`CSCR_A_R0][`CSCR_B_SOFT_RST] = 1'b1;
      end else begin
        st_next.regs[addr] = data;
        st_next.regs[`CSCR_A_R0][`CSCR_B_SOFT_RST] = 1'b0;
        if (addr == `CSCR_A_FBDIV) begin
          st_next.sync_cnt = `CSCR_SYNC_CYC;
        end
      end
    end

    // ---------------------------------------------
    // lock detect
    // ---------------------------------------------
    // one ref_clk cycle stands in for one detector cycle
    if (!st_reg.ok_s[1]) begin
      st_next.ok_cnt = '0;
      st_next.locked = 1'b0;
    end else if (st_reg.ok_cnt >= st_reg.regs[`CSCR_A_PLLGAIN][19:6]) begin
      st_next.locked = 1'b1;
    end else begin
      st_next.ok_cnt = st_reg.ok_cnt + 14'h0001;
    end

    // ---------------------------------------------
    // sync condition
    // ---------------------------------------------
    hold = st_reg.regs[`CSCR_A_LDPIN][`CSCR_B_HOLD_SYNC] & ~st_reg.locked;
    st_next.sync_on = (st_next.sync_cnt != 4'h0) | hold;

    // ---------------------------------------------
    // output pair dividers
    // ---------------------------------------------
    // counting 2n cycles with the first n high keeps odd divides at
    // exact half duty without a falling-edge flop
    for (int p = 0; p < `CSCR_NPAIR; p++) begin
      // kept as a flop so the mode flag leaves the block straight from a register
      st_next.ext[p] = div_of(st_next.regs[p]) >= `CSCR_EXT_MIN;
      dv   = div_of(st_reg.regs[p]);
      per  = {dv, 1'b0} - 12'h001;
      stop = st_reg.regs[p][`CSCR_B_PATH_OFF] |
             st_reg.regs[`CSCR_A_R1][`CSCR_B_PWRDN] |
             (dv == 11'h000) |
             (st_reg.sync_on &
              ~st_reg.regs[`CSCR_A_SYNC][`CSCR_B_EXCL_LO + p]);
      if (stop) begin
        st_next.dcnt[p] = '0;
        st_next.clk_out[2*p]   = 1'b0;
        st_next.clk_out[2*p+1] = 1'b0;
      end else begin
        st_next.dcnt[p] = (st_reg.dcnt[p] >= per) ? 12'h000 : st_reg.dcnt[p] + 12'h001;
        st_next.clk_out[2*p]   = st_next.dcnt[p] < {1'b0, dv};
        st_next.clk_out[2*p+1] = st_next.dcnt[p] < {1'b0, dv};
      end
    end

    if (!rst_n) begin
      st_next          = '0;
      st_next.regs     = dev_defaults();
    end
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------
  // outputs, all taken from the state register
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CSCR_NPAIR; g++) begin : g_pair
      assign pair_path_off[g]     = st_reg.regs[g][`CSCR_B_PATH_OFF];
      assign pair_divide_value[g] = st_reg.regs[g][`CSCR_B_DIV_HI:`CSCR_B_DIV_LO];
      assign pair_extended[g]     = st_reg.ext[g];
      assign pair_sync_exclude[g] = st_reg.regs[`CSCR_A_SYNC][`CSCR_B_EXCL_LO + g];
    end
  endgenerate

  assign clock_output_n       = st_reg.clk_out;
  assign device_powerdown     = st_reg.regs[`CSCR_A_R1][`CSCR_B_PWRDN];
  assign soft_reset_bit       = st_reg.regs[`CSCR_A_R0][`CSCR_B_SOFT_RST];
  assign crystal_osc_on       = st_reg.regs[`CSCR_A_SYNC][`CSCR_B_XTAL];
  assign reference_doubler_on = st_reg.regs[`CSCR_A_PLLGAIN][`CSCR_B_DOUBLER];
  assign lock_pin_select      = st_reg.regs[`CSCR_A_LDPIN][31:27];
  assign lock_pin_driver      = st_reg.regs[`CSCR_A_LDPIN][26:24];
  assign charge_pump_gain     = st_reg.regs[`CSCR_A_PLLGAIN][27:26];
  assign lock_detect_count    = st_reg.regs[`CSCR_A_PLLGAIN][19:6];
  assign ref_div              = st_reg.regs[`CSCR_A_REFDIV][31:20];
  assign fb_div               = st_reg.regs[`CSCR_A_FBDIV][22:5];
  assign fb_cal_div           = st_reg.regs[`CSCR_A_CALDIV][22:5];
  assign fb_prescale          = st_reg.regs[`CSCR_A_FBDIV][26:24];
  assign register_write_lock  = st_reg.regs[`CSCR_A_WLOCK][`CSCR_B_WLOCK];
  assign digital_lock_detect  = st_reg.locked;
  assign sync_active          = st_reg.sync_on;

endmodule // cscr_device

//--- hdl/cscr_host.sv
// serial programming host with an Avalon-MM register port
`timescale 1ns/100ps
`include "cscr_params.svh"
module cscr_host (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  cscr_link_if.host        link
);

  cscr_pkg::cscr_hst_s r;
  cscr_pkg::cscr_hst_s n;

  always_comb begin
    logic tick;
    tick = (r.hcnt + 8'h01) >= r.half;
    n = r;
    n.wait_r = 1'b1;

    // ---------------------------------------------
    // bus slave
    // ---------------------------------------------
    // a command write stalls while a frame is on the wire
    if ((avs_read || avs_write) && r.wait_r) begin
      if (avs_read) begin
        n.wait_r = 1'b0;
        case (avs_address)
          `CSCR_AV_CMD:  n.rdata = r.cmd;
          `CSCR_AV_STAT: n.rdata = {r.frames, 15'h0000, r.state != cscr_pkg::CSCR_IDLE};
          `CSCR_AV_CFG:  n.rdata = {24'h00_0000, r.half};
          default:       n.rdata = 32'h0000_0000;
        endcase
      end else if (avs_address == `CSCR_AV_CMD) begin
        if (r.state == cscr_pkg::CSCR_IDLE) begin
          n.wait_r = 1'b0;
          n.cmd    = avs_writedata;
          n.state  = cscr_pkg::CSCR_SHIFT;
          n.bitn   = 5'h1f;
          n.hcnt   = 8'h00;
          n.sclk   = 1'b0;
          n.sdata  = avs_writedata[31];
        end
      end else begin
        n.wait_r = 1'b0;
        if (avs_address == `CSCR_AV_CFG) begin
          // below this the far end could miss clock edges
          n.half = (avs_writedata[7:0] < `CSCR_SCLK_HMIN) ? `CSCR_SCLK_HMIN : avs_writedata[7:0];
        end
      end
    end

    // ---------------------------------------------
    // serial frame, msb first, data sampled on sclk rise
    // ---------------------------------------------
    if (r.state != cscr_pkg::CSCR_IDLE) begin
      n.hcnt = tick ? 8'h00 : r.hcnt + 8'h01;
    end
    case (r.state)
      cscr_pkg::CSCR_IDLE: begin
      end
      cscr_pkg::CSCR_SHIFT: begin
        if (tick) begin
          n.sclk = ~r.sclk;
          if (r.sclk) begin
            if (r.bitn == 5'h00) begin
              n.state = cscr_pkg::CSCR_LATCH;
              n.le    = 1'b1;
            end else begin
              n.bitn  = r.bitn - 5'h01;
              n.sdata = r.cmd[r.bitn - 5'h01];
            end
          end
        end
      end
      cscr_pkg::CSCR_LATCH: begin
        if (tick) begin
          n.le    = 1'b0;
          n.state = cscr_pkg::CSCR_GAP;
        end
      end
      cscr_pkg::CSCR_GAP: begin
        if (tick) begin
          n.state  = cscr_pkg::CSCR_IDLE;
          n.frames = r.frames + 16'h0001;
          n.sdata  = 1'b0;
        end
      end
      default: n.state = cscr_pkg::CSCR_IDLE;
    endcase

    if (!rst_n) begin
      n        = '0;
      n.state  = cscr_pkg::CSCR_IDLE;
      n.half   = `CSCR_SCLK_HALF;
      n.wait_r = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    r <= n;
  end

  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wait_r;
  assign link.sclk       = r.sclk;
  assign link.sdata      = r.sdata;
  assign link.latch_en   = r.le;

endmodule // cscr_host

//--- hdl/cscr_link_if.sv
// three-wire serial programming link between host and configuration bank
`timescale 1ns/100ps
interface cscr_link_if;
  logic sclk;
  logic sdata;
  logic latch_en;
  modport host (output sclk, output sdata, output latch_en);
  modport dev  (input sclk, input sdata, input latch_en);
endinterface // cscr_link_if

//--- hdl/cscr_params.svh
// constants of the clock synthesiser configuration bank and its serial host
// ---------------------------------------------
// Summary of operation
// - pair register bit 31 powers pair off
// - register 0 bit 17 reloads all defaults
// - soft reset write ignores its other fields
// - soft reset acts at latch enable fall
// - any later write taken past the register lock, other than a soft reset, clears the reset bit
// - host rewrites register 0 after soft reset
// - register 1 bit 17 powers device down
// - eleven-bit divide at 15:5, zero reserved
// - divider output always 50 percent duty
// - divide 26 or more means extended mode
// - feedback write syncs; host keeps exclusions clear
// - register 31 bit 5 locks registers 0-30
// - lock after programmed in-window cycle count
// - reference divider at register 28 31:20
// - feedback divider at register 30 22:5
// - host writes calibration divider equal feedback
// - prescaler at register 30 26:24
// - register 12 bit 23 holds sync until lock
// - register 26 bit 29 doubles reference
// - lock pin select 31:27, driver 26:24
// - registers 0-5 serve output pairs in order
// - register 11 bit 5 enables crystal oscillator
// - register 11 bits 20-25 exclude pairs from sync
// ---------------------------------------------
`ifndef CSCR_PARAMS_SVH
`define CSCR_PARAMS_SVH
`define CSCR_NPAIR        6
`define CSCR_B_PATH_OFF   31
`define CSCR_B_DIV_LO     5
`define CSCR_B_DIV_HI     15
`define CSCR_B_SOFT_RST   17
`define CSCR_B_PWRDN      17
`define CSCR_B_XTAL       5
`define CSCR_B_EXCL_LO    20
`define CSCR_B_HOLD_SYNC  23
`define CSCR_B_DOUBLER    29
`define CSCR_B_WLOCK      5
`define CSCR_EXT_MIN      11'h01a
`define CSCR_A_R0         5'h00
`define CSCR_A_R1         5'h01
`define CSCR_A_SYNC       5'h0b
`define CSCR_A_LDPIN      5'h0c
`define CSCR_A_GPO0       5'h0d
`define CSCR_A_GPO1       5'h0e
`define CSCR_A_PLLGAIN    5'h1a
`define CSCR_A_REFDIV     5'h1c
`define CSCR_A_CALDIV     5'h1d
`define CSCR_A_FBDIV      5'h1e
`define CSCR_A_WLOCK      5'h1f
`define CSCR_D_PAIR       32'h0000_0320
`define CSCR_D_PAIR3      32'h0000_0020
`define CSCR_D_SYNC       32'h0180_0000
`define CSCR_D_LDPIN      32'h1b00_0000
`define CSCR_D_GPO0       32'h0302_0000
`define CSCR_D_GPO1       32'h0800_0000
`define CSCR_D_PLLGAIN    32'h0c08_0000
`define CSCR_D_REFDIV     32'h0040_0000
`define CSCR_D_CALDIV     32'h0700_0600
`define CSCR_D_FBDIV      32'h0200_0600
`define CSCR_SYNC_CYC     4'h8
`define CSCR_SCLK_HALF    8'h05
`define CSCR_SCLK_HMIN    8'h02
`define CSCR_AV_CMD       4'h0
`define CSCR_AV_STAT      4'h4
`define CSCR_AV_CFG       4'h8
`endif

//--- hdl/cscr_pkg.sv
// types shared by the configuration bank and its serial host
package cscr_pkg;
  typedef logic [31:0][31:0] cscr_bank_t;
  typedef struct packed {
    logic [1:0]        sclk_s;
    logic [1:0]        sdat_s;
    logic [1:0]        le_s;
    logic [1:0]        ok_s;
    logic              sclk_d;
    logic              le_d;
    logic [31:0]       shift;
    cscr_bank_t        regs;
    logic [3:0]        sync_cnt;
    logic              sync_on;
    logic [13:0]       ok_cnt;
    logic              locked;
    logic [5:0][11:0]  dcnt;
    logic [11:0]       clk_out;
    logic [5:0]        ext;
  } cscr_dev_s;
  typedef enum logic [3:0] {
    CSCR_IDLE  = 4'b0001,
    CSCR_SHIFT = 4'b0010,
    CSCR_LATCH = 4'b0100,
    CSCR_GAP   = 4'b1000
  } cscr_hst_e;
  typedef struct packed {
    cscr_hst_e   state;
    logic [7:0]  hcnt;
    logic [7:0]  half;
    logic [4:0]  bitn;
    logic [31:0] cmd;
    logic [15:0] frames;
    logic        sclk;
    logic        sdata;
    logic        le;
    logic        wait_r;
    logic [31:0] rdata;
  } cscr_hst_s;
endpackage

//--- verification/cscr_checker.sv
// concurrent checks on the serial link and the bank outputs
`timescale 1ns/100ps
module cscr_checker (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             sclk,
  input wire logic             sdata,
  input wire logic             latch_en,
  input wire logic             phase_in_window,
  input wire logic [11:0]      clock_output_n,
  input wire logic [5:0]       pair_path_off,
  input wire logic [5:0][10:0] pair_divide_value,
  input wire logic [5:0]       pair_extended,
  input wire logic             device_powerdown,
  input wire logic             soft_reset_bit,
  input wire logic             register_write_lock,
  input wire logic             digital_lock_detect,
  input wire logic             sync_active,
  input wire logic [17:0]      fb_div,
  input wire logic [13:0]      lock_detect_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // raw in-window run length; saturates so a long lock never wraps
  logic [15:0] win_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !phase_in_window) win_reg <= 16'h0000;
    else if (win_reg != 16'hffff) win_reg <= win_reg + 16'h0001;
  end
  // ------
  // properties
  // ------
  chk_ext_mode: assert property ($stable(pair_divide_value) |->
    pair_extended[1] == (pair_divide_value[1] >= 11'h01a)) else $error("extended flag wrong");
  chk_pair_equal: assert property (clock_output_n[0] == clock_output_n[1]) else $error("pair outputs differ");
  chk_path_off: assert property (pair_path_off[5] [*3] |-> clock_output_n[11:10] == 2'b00)
    else $error("powered-down pair toggles");
  chk_pwrdn_quiet: assert property (device_powerdown [*3] |-> clock_output_n == 12'h000)
    else $error("outputs run in powerdown");
  chk_lock_count: assert property ($rose(digital_lock_detect) |->
    win_reg >= {2'b00, lock_detect_count} + 16'h0001) else $error("lock came early");
  chk_lock_drop: assert property ($fell(phase_in_window) |-> ##[1:4] !digital_lock_detect)
    else $error("lock kept after miss");
  chk_sync_len: assert property ($rose(sync_active) |-> sync_active [*8]) else $error("sync too short");
  chk_fb_sync: assert property ($changed(fb_div) && !soft_reset_bit |-> ##[0:3] sync_active)
    else $error("no sync after feedback write");
  chk_soft_dflt: assert property ($rose(soft_reset_bit) |->
    pair_divide_value[0] == 11'h019 && fb_div == 18'h0_0030 && !register_write_lock) else $error("defaults not loaded");
  chk_lock_hold: assert property ($past(register_write_lock) && register_write_lock |->
    $stable(fb_div) && $stable(pair_divide_value)) else $error("locked register changed");
  chk_latch_quiet: assert property (latch_en |-> !sclk) else $error("clock runs while latching");
  chk_sdata_hold: assert property (sclk && $past(sclk) |-> $stable(sdata)) else $error("data moved in high");
endmodule // cscr_checker

//--- verification/tb_clock_synth_config_registers.sv
// self-checking bench joining the serial host and the configuration bank
`timescale 1ns/100ps
module tb_clock_synth_config_registers;
  logic             ref_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             phase_in_window = 1'b0;
  logic [3:0]       avs_address = 4'h0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0000_0000;
  logic [31:0]      avs_readdata, q;
  logic             avs_waitrequest, device_powerdown, soft_reset_bit, crystal_osc_on;
  logic             reference_doubler_on, register_write_lock, digital_lock_detect, sync_active;
  logic [11:0]      clock_output_n, ref_div;
  logic [5:0]       pair_path_off, pair_extended, pair_sync_exclude;
  logic [5:0][10:0] pair_divide_value;
  logic [4:0]       lock_pin_select;
  logic [2:0]       lock_pin_driver, fb_prescale;
  logic [1:0]       charge_pump_gain;
  logic [13:0]      lock_detect_count;
  logic [17:0]      fb_div, fb_cal_div;
  int               failures = 0, n_tests = 0, nfr = 0, sync_seen = 0, s, p, i;
  cscr_link_if lnk ();
  cscr_host cscr_host_inst (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .link(lnk));
  cscr_device cscr_device_inst (.ref_clk, .rst_n, .link(lnk), .phase_in_window, .clock_output_n,
    .pair_path_off, .pair_divide_value, .pair_extended, .pair_sync_exclude, .device_powerdown,
    .soft_reset_bit, .crystal_osc_on, .reference_doubler_on, .lock_pin_select, .lock_pin_driver,
    .charge_pump_gain, .lock_detect_count, .ref_div, .fb_div, .fb_cal_div, .fb_prescale,
    .register_write_lock, .digital_lock_detect, .sync_active);
  cscr_checker cscr_checker_inst (.ref_clk, .rst_n, .sclk(lnk.sclk), .sdata(lnk.sdata),
    .latch_en(lnk.latch_en), .phase_in_window, .clock_output_n, .pair_path_off, .pair_divide_value,
    .pair_extended, .device_powerdown, .soft_reset_bit, .register_write_lock, .digital_lock_detect,
    .sync_active, .fb_div, .lock_detect_count);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge sync_active) sync_seen++;
  // ------
  // access tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    for (k = 0; k < 2000; k++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 2000) begin failures++; summarize(); end
    @(posedge ref_clk);
  endtask
  task automatic dev_wr(input logic [4:0] r, input logic [31:0] v);
    int k;
    bus(1'b0, 4'h0, {v[31:5], r});
    nfr++;
    for (k = 0; k < 2000; k++) begin
      bus(1'b1, 4'h4, 32'h0000_0000);
      if (q[0] === 1'b0) break;
    end
    if (k == 2000) begin failures++; summarize(); end
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic quiet(input logic [11:0] m);
    logic [11:0] acc;
    acc = 12'h000;
    repeat (80) begin @(posedge ref_clk); acc = acc | (clock_output_n & m); end
    chk("quiet", 32'h0000_0000, {20'h0_0000, acc});
  endtask
  task automatic duty(input int b, input int dv);
    int k, h;
    for (k = 0; k < 3000 && clock_output_n[b] !== 1'b0; k++) @(posedge ref_clk);
    for (k = 0; k < 3000 && clock_output_n[b] !== 1'b1; k++) @(posedge ref_clk);
    for (h = 0; h < 3000 && clock_output_n[b] === 1'b1; h++) @(posedge ref_clk);
    for (k = 0; k < 3000 && clock_output_n[b] === 1'b0; k++) @(posedge ref_clk);
    chk("duty", {16'(dv), 16'(dv)}, {16'(h), 16'(k)});
  endtask
  // ------
  // tests
  // ------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("pairs", {pair_divide_value[0], pair_divide_value[3], pair_sync_exclude}, {11'h019, 11'h001, 6'h18});
    chk("plldef", {ref_div, fb_prescale, lock_detect_count}, {12'h004, 3'h2, 14'h2000});
    chk("fbdef", {fb_div, 8'h00, pair_path_off}, {18'h0_0030, 8'h00, 6'h00});
    chk("misc", {crystal_osc_on, reference_doubler_on, register_write_lock, lock_pin_select, lock_pin_driver},
      {3'h0, 5'h03, 3'h3});
    bus(1'b0, 4'h8, 32'h0000_0001);
    bus(1'b1, 4'h8, 32'h0000_0000);
    chk("cfg", 32'h0000_0002, q);
    bus(1'b0, 4'hc, 32'h0000_0055);
    bus(1'b1, 4'hc, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    bus(1'b0, 4'h8, 32'h0000_0005);
    $display("test defaults done");
    for (p = 0; p < 6; p++) begin
      dev_wr(p[4:0], {p == 5, 15'h0000, 11'(24 + p), 5'h00});
      chk("pair", {pair_path_off[p], pair_extended[p], pair_divide_value[p]}, {p == 5, p >= 2, 11'(24 + p)});
    end
    duty(0, 24);
    duty(2, 25);
    quiet(12'hc00);
    $display("test pairs done");
    dev_wr(5'h0b, 32'h0000_0020);
    dev_wr(5'h1a, 32'h2400_0280);
    chk("pllctl", {crystal_osc_on, reference_doubler_on, charge_pump_gain, lock_detect_count, pair_sync_exclude},
      {2'h3, 2'h1, 14'h000a, 6'h00});
    dev_wr(5'h0c, 32'h2980_0000);
    chk("ldpin", {lock_pin_select, lock_pin_driver, sync_active}, {5'h05, 3'h1, 1'b1});
    phase_in_window <= 1'b1;
    for (i = 0; i < 100 && digital_lock_detect !== 1'b1; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk("lock", {i >= 11, digital_lock_detect, sync_active}, 3'h6);
    phase_in_window <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("unlock", {digital_lock_detect, sync_active}, 2'h1);
    dev_wr(5'h0c, 32'h1b00_0000);
    $display("test lock done");
    s = sync_seen;
    dev_wr(5'h1c, 32'hfff0_0000);
    dev_wr(5'h1d, 32'h0000_7d00);
    dev_wr(5'h1e, 32'h0300_7d00);
    chk("refdiv", 12'hfff, ref_div);
    chk("fbdiv", {fb_prescale, fb_div}, {3'h3, 18'h0_03e8});
    chk("caldiv", 18'h0_03e8, fb_cal_div);
    chk("syncs", 32'h0000_0001, s == sync_seen - 1);
    $display("test dividers done");
    dev_wr(5'h1f, 32'h0000_0020);
    dev_wr(5'h1c, 32'h0070_0000);
    dev_wr(5'h00, 32'h0002_0000);
    chk("locked", {register_write_lock, soft_reset_bit, ref_div}, {2'h2, 12'hfff});
    dev_wr(5'h1f, 32'h0000_0000);
    dev_wr(5'h1c, 32'h0070_0000);
    chk("unlocked", {register_write_lock, ref_div}, {1'b0, 12'h007});
    $display("test write lock done");
    dev_wr(5'h00, 32'h8002_0c80);
    chk("softrst", {soft_reset_bit, pair_path_off[0], pair_divide_value[0], ref_div},
      {2'h2, 11'h019, 12'h004});
    chk("softdef", {fb_div, pair_sync_exclude}, {18'h0_0030, 6'h18});
    dev_wr(5'h01, 32'h0002_0060);
    chk("pwrdn", {soft_reset_bit, device_powerdown, pair_divide_value[1]}, {2'h1, 11'h003});
    quiet(12'hfff);
    dev_wr(5'h01, 32'h0000_0060);
    chk("pwrup", 1'b0, device_powerdown);
    dev_wr(5'h00, 32'h0000_0640);
    chk("rewrite", {pair_divide_value[0], pair_extended[0]}, {11'h032, 1'b1});
    bus(1'b1, 4'h4, 32'h0000_0000);
    chk("frames", {16'(nfr), 16'h0000}, {q[31:16], 15'h0000, q[0]});
    $display("test soft reset done");
    summarize();
  end
endmodule // tb_clock_synth_config_registers
